// [inc/hsb_consts.svh]
// Constants of the status block reporter: offsets, field positions, codes.
// Assumes inclusion by bare name from hw/ and inc/ sources.
`ifndef HSB_CONSTS_SVH
`define HSB_CONSTS_SVH

// Word offsets inside one status block
`define HSB_OFS_CMD_ID 8'h00
`define HSB_OFS_FLAGS 8'h04
`define HSB_OFS_SENSE_LO 8'h08
`define HSB_OFS_SENSE_HI 8'h0c
`define HSB_WORDS_PER_BLK 2'h3

// Flags byte bit positions
`define HSB_FLG_DONE 0
`define HSB_FLG_ERR 1
`define HSB_FLG_RETRY 2
`define HSB_FLG_TRUNC 3
`define HSB_FLG_CONT 4

// Destination selector values
`define HSB_SEL_TARGET_MAX 8'h07
`define HSB_SEL_BOARD 8'hff

// Sense reporting figures
`define HSB_SEQ_MAX 6'h20
`define HSB_BYTES_PER_BLK 6'h08
`define HSB_SEL_BASIC 6'h08
`define HSB_SEL_EXT 6'h10

// Board-control command codes
`define HSB_CMD_START_LIST 8'h01
`define HSB_CMD_STOP_LIST 8'h02
`define HSB_CMD_IDENTIFY 8'h05
`define HSB_CMD_STATS 8'h06
`define HSB_CMD_GEN_OPTS 8'h07
`define HSB_CMD_UNIT_OPTS 8'h08
`define HSB_CMD_SELF_TEST 8'h09
`define HSB_CMD_HARD_RESET 8'h10
`define HSB_CMD_BOARD_INFO 8'h15
`define HSB_CMD_EXT_STATS 8'h16
`define HSB_CMD_EXT_UNIT_OPTS 8'h18

// Error codes raised by the reporter itself (arbitrary values)
`define HSB_ERR_BAD_SELECTOR 8'h40
`define HSB_ERR_BAD_COMMAND 8'h41

`endif

// [inc/hsb_pkg.sv]
// Types shared by the status block reporter modules.
// Assumes nothing beyond a SystemVerilog compiler.
package hsb_pkg;
  typedef enum logic [1:0] {
    HSB_IDLE = 2'b00,
    HSB_WAIT = 2'b01,
    HSB_EMIT = 2'b10
  } hsb_state_t;

  typedef enum logic [1:0] {
    HSB_MODE_NONE = 2'b00,
    HSB_MODE_SEQ = 2'b01,
    HSB_MODE_SEL = 2'b10
  } hsb_mode_t;
endpackage

// [hw/hsb_sense_pick.sv]
// Sense byte index selection for one sense word of one status block.
// Assumes selection fields packed byte 0 in the low bits.
`timescale 1ns/100ps
`default_nettype none
`include "hsb_consts.svh"
module hsb_sense_pick #(
  parameter int MAX_SEL = 16
) (
  // Reporting setup
  input wire hsb_pkg::hsb_mode_t mode,
  input wire logic [5:0] byte_total,
  input wire logic [8*MAX_SEL-1:0] sel_fields,
  // Position
  input wire logic [1:0] blk,
  input wire logic half,
  // Result: four byte indices and their keep bits
  output logic [31:0] idx,
  output logic [3:0] keep
);
  // Position of slot k within the whole report
  function automatic logic [5:0] pos_of(input logic [1:0] b,
                                        input logic h,
                                        input logic [1:0] k);
    pos_of = {1'b0, b, h, k};
  endfunction

  genvar k;
  generate
    for (k = 0; k < 4; k++) begin : g_slot
      wire logic [5:0] pos = pos_of(blk, half, 2'(k));
      wire logic sel_in = (pos < 6'(MAX_SEL));
      wire logic [7:0] sel_val = sel_in ? sel_fields[8*pos[3:0] +: 8] :
        8'h00;
      // Selectable mode reads the slot field, others read in order
      assign idx[8*k +: 8] = (mode == hsb_pkg::HSB_MODE_SEL) ?
        sel_val : {2'h0, pos};
      // Bytes past the enabled count stay zero
      assign keep[k] = (mode != hsb_pkg::HSB_MODE_NONE) &&
        (pos < byte_total);
    end
  endgenerate
endmodule
`default_nettype wire

// [hw/hsb_reporter.sv]
// Command classifier and status block writer of the host adapter.
// Assumes a command executor that reports completion, and a sense buffer
// read combinationally through four byte ports in the same cycle.
`timescale 1ns/100ps
`default_nettype none
`include "hsb_consts.svh"
module hsb_reporter #(
  parameter int MAX_SEL = 16,
  parameter int SEQ_MAX = 32
) (
  // Clock, reset, enable
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  // Parameter block intake
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic [31:0] cmd_ident,
  input wire logic [7:0] destination_selector,
  input wire logic [7:0] cmd_code,
  // Classification towards the executor
  output logic pass_through_reg,
  output logic board_ctrl_reg,
  output logic [2:0] target_reg,
  output logic [7:0] board_cmd_reg,
  output logic exec_start_reg,
  // Completion from the executor
  input wire logic exec_done,
  input wire logic exec_error,
  input wire logic [7:0] exec_err_code,
  input wire logic [7:0] scsi_status,
  input wire logic data_truncated,
  input wire logic retried,
  input wire logic check_condition,
  input wire logic sense_inhibit,
  // Sense reporting setup
  input wire logic [5:0] sense_count,
  input wire logic ext_unit_opts,
  input wire logic [8*MAX_SEL-1:0] sel_fields,
  // Sense buffer read ports
  output logic [31:0] sense_rd_idx,
  input wire logic [31:0] sense_rd_data,
  // Status word output
  output logic stat_valid_reg,
  input wire logic stat_ready,
  output logic [31:0] stat_word_reg,
  output logic [7:0] stat_offset_reg,
  output logic [1:0] stat_block_reg,
  output logic stat_last_reg,
  // Progress
  output logic command_done_bit_reg
);
  // Logic assumes at most four blocks and a sixteen-byte selection set
  generate
    if (MAX_SEL != 16 || SEQ_MAX != 32) begin : g_bad_param
      $error("hsb_reporter serves only MAX_SEL 16 and SEQ_MAX 32");
    end
  endgenerate

  // Index of the last block needed for n bytes, block 0 when n is zero
  function automatic logic [1:0] last_blk(input logic [5:0] n);
    logic [5:0] m;
    m = (n == 6'h00) ? 6'h00 : n - 6'h01;
    last_blk = m[4:3];
  endfunction

  // True for a code the board-control decoder knows
  function automatic logic code_ok(input logic [7:0] c);
    case (c)
      `HSB_CMD_START_LIST, `HSB_CMD_STOP_LIST, `HSB_CMD_IDENTIFY,
      `HSB_CMD_STATS, `HSB_CMD_GEN_OPTS, `HSB_CMD_UNIT_OPTS,
      `HSB_CMD_SELF_TEST, `HSB_CMD_HARD_RESET, `HSB_CMD_BOARD_INFO,
      `HSB_CMD_EXT_STATS, `HSB_CMD_EXT_UNIT_OPTS: code_ok = 1'b1;
      default: code_ok = 1'b0;
    endcase
  endfunction

  hsb_pkg::hsb_state_t state_reg, state_next;
  logic [31:0] ident_reg;
  logic [7:0] err_code_reg;
  logic [7:0] scsi_reg;
  logic [7:0] flags_reg;
  logic [5:0] total_reg;
  hsb_pkg::hsb_mode_t mode_reg;
  logic [1:0] last_blk_reg;
  logic [1:0] blk_reg;
  logic [1:0] wrd_reg;

  // Intake decode
  wire logic take = clk_en && cmd_valid && cmd_ready;
  wire logic sel_target = destination_selector <= `HSB_SEL_TARGET_MAX;
  wire logic sel_board = destination_selector == `HSB_SEL_BOARD;
  wire logic board_bad = sel_board && !code_ok(cmd_code);
  wire logic intake_err = !(sel_target || sel_board) || board_bad;
  wire logic [7:0] intake_code = board_bad ? `HSB_ERR_BAD_COMMAND :
    `HSB_ERR_BAD_SELECTOR;
  assign cmd_ready = (state_reg == hsb_pkg::HSB_IDLE);

  // Sense mode chosen at completion
  wire logic sel_any = |sel_fields;
  wire logic sense_on = pass_through_reg && check_condition &&
    !sense_inhibit;
  wire logic [5:0] cnt_clip = (sense_count > 6'(SEQ_MAX)) ?
    6'(SEQ_MAX) : sense_count;
  wire logic [5:0] sel_n = ext_unit_opts ? `HSB_SEL_EXT :
    `HSB_SEL_BASIC;
  wire hsb_pkg::hsb_mode_t mode_new = !sense_on ? hsb_pkg::HSB_MODE_NONE :
    (sense_count == 6'h00 && sel_any) ? hsb_pkg::HSB_MODE_SEL :
    hsb_pkg::HSB_MODE_SEQ;
  wire logic [5:0] total_new = !sense_on ? 6'h00 :
    (sense_count != 6'h00) ? cnt_clip :
    sel_any ? sel_n : `HSB_BYTES_PER_BLK;
  wire logic fin = clk_en && state_reg == hsb_pkg::HSB_WAIT && exec_done;

  // Flags byte: extra bits only for pass-through blocks
  wire logic [7:0] flags_new =
    (8'(exec_error) << `HSB_FLG_ERR) |
    (8'h01 << `HSB_FLG_DONE) |
    (pass_through_reg ? ((8'(data_truncated) << `HSB_FLG_TRUNC) |
      (8'(retried) << `HSB_FLG_RETRY)) : 8'h00);

  // Sense byte positions for the word being built
  wire logic [31:0] pick_idx;
  wire logic [3:0] pick_keep;
  hsb_sense_pick #(
    .MAX_SEL(MAX_SEL)
  ) u_pick (
    .mode(mode_reg),
    .byte_total(total_reg),
    .sel_fields(sel_fields),
    .blk(blk_reg),
    .half(wrd_reg[0]),
    .idx(pick_idx),
    .keep(pick_keep)
  );
  assign sense_rd_idx = pick_idx;

  // Word contents; byte at offset +k sits in bits 8k+7..8k
  wire logic cont = blk_reg != 2'h0;
  wire logic [7:0] flags_out = flags_reg |
    (8'(cont) << `HSB_FLG_CONT);
  wire logic [31:0] sense_word = sense_rd_data &
    {{8{pick_keep[3]}}, {8{pick_keep[2]}}, {8{pick_keep[1]}},
     {8{pick_keep[0]}}};
  wire logic [31:0] word_out = (wrd_reg == 2'h0) ? ident_reg :
    (wrd_reg == 2'h1) ? {flags_out, err_code_reg, scsi_reg, 8'h00} :
    board_ctrl_reg ? 32'h0000_0000 : sense_word;
  wire logic [7:0] ofs_out = {4'h0, wrd_reg, 2'h0};
  wire logic slot_free = !stat_valid_reg || stat_ready;
  wire logic push = clk_en && state_reg == hsb_pkg::HSB_EMIT && slot_free;
  wire logic blk_end = wrd_reg == `HSB_WORDS_PER_BLK;
  wire logic all_end = blk_end && blk_reg == last_blk_reg;

  // Next state
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      hsb_pkg::HSB_IDLE: begin
        if (take) begin
          state_next = intake_err ? hsb_pkg::HSB_EMIT : hsb_pkg::HSB_WAIT;
        end
      end
      hsb_pkg::HSB_WAIT: begin
        if (fin) begin
          state_next = hsb_pkg::HSB_EMIT;
        end
      end
      hsb_pkg::HSB_EMIT: begin
        if (push && all_end) begin
          state_next = hsb_pkg::HSB_IDLE;
        end
      end
      default: state_next = hsb_pkg::HSB_IDLE;
    endcase
  end

  // Control state
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      state_reg <= hsb_pkg::HSB_IDLE;
    end else if (clk_en) begin
      state_reg <= state_next;
    end
  end

  // Intake capture; a refused block completes at once with a code
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      ident_reg <= 32'h0000_0000;
      pass_through_reg <= 1'b0;
      board_ctrl_reg <= 1'b0;
      target_reg <= 3'h0;
      board_cmd_reg <= 8'h00;
      exec_start_reg <= 1'b0;
    end else if (clk_en) begin
      exec_start_reg <= take && !intake_err;
      if (take) begin
        ident_reg <= cmd_ident;
        pass_through_reg <= sel_target;
        board_ctrl_reg <= sel_board;
        target_reg <= destination_selector[2:0];
        board_cmd_reg <= sel_board ? cmd_code : 8'h00;
      end
    end
  end

  // Completion capture
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      err_code_reg <= 8'h00;
      scsi_reg <= 8'h00;
      flags_reg <= 8'h00;
      total_reg <= 6'h00;
      mode_reg <= hsb_pkg::HSB_MODE_NONE;
      last_blk_reg <= 2'h0;
    end else if (clk_en) begin
      if (take && intake_err) begin
        err_code_reg <= intake_code;
        scsi_reg <= 8'h00;
        flags_reg <= (8'h01 << `HSB_FLG_ERR) |
          (8'h01 << `HSB_FLG_DONE);
        total_reg <= 6'h00;
        mode_reg <= hsb_pkg::HSB_MODE_NONE;
        last_blk_reg <= 2'h0;
      end else if (fin) begin
        err_code_reg <= exec_error ? exec_err_code : 8'h00;
        scsi_reg <= pass_through_reg ? scsi_status : 8'h00;
        flags_reg <= flags_new;
        total_reg <= total_new;
        mode_reg <= mode_new;
        last_blk_reg <= last_blk(total_new);
      end
    end
  end

  // Word and block walk through the report
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      blk_reg <= 2'h0;
      wrd_reg <= 2'h0;
    end else if (clk_en) begin
      if (state_reg != hsb_pkg::HSB_EMIT) begin
        blk_reg <= 2'h0;
        wrd_reg <= 2'h0;
      end else if (push) begin
        wrd_reg <= wrd_reg + 2'h1;
        if (blk_end) begin
          blk_reg <= blk_reg + 2'h1;
        end
      end
    end
  end

  // Output word register; stalls while the host side is not ready
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      stat_valid_reg <= 1'b0;
      stat_word_reg <= 32'h0000_0000;
      stat_offset_reg <= 8'h00;
      stat_block_reg <= 2'h0;
      stat_last_reg <= 1'b0;
    end else if (clk_en && slot_free) begin
      stat_valid_reg <= push;
      if (push) begin
        stat_word_reg <= word_out;
        stat_offset_reg <= ofs_out;
        stat_block_reg <= blk_reg;
        stat_last_reg <= all_end;
      end
    end
  end

  // Done level: low from intake until the last word is pushed
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      command_done_bit_reg <= 1'b0;
    end else if (clk_en) begin
      if (take) begin
        command_done_bit_reg <= 1'b0;
      end else if (push && all_end) begin
        command_done_bit_reg <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// [dv/hsb_reporter_properties.sv]
// Port-level checks of the status block reporter.
// Assumes binding to hsb_reporter; one clock, sync reset.
`timescale 1ns/100ps
`default_nettype none
module hsb_reporter_properties (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // Intake
  input wire logic clk_en,
  input wire logic cmd_valid,
  input wire logic cmd_ready,
  input wire logic [31:0] cmd_ident,
  input wire logic [7:0] destination_selector,
  input wire logic [7:0] cmd_code,
  input wire logic board_ctrl_reg,
  input wire logic [7:0] board_cmd_reg,
  input wire logic exec_start_reg,
  input wire logic exec_done,
  // Status words
  input wire logic stat_valid_reg,
  input wire logic stat_ready,
  input wire logic [31:0] stat_word_reg,
  input wire logic [7:0] stat_offset_reg,
  input wire logic [1:0] stat_block_reg,
  input wire logic stat_last_reg,
  input wire logic command_done_bit_reg
);
  logic [31:0] id_reg;
  logic take;
  logic flg;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  // Identifier of the command in flight
  assign take = cmd_valid && cmd_ready && clk_en;
  assign flg = stat_valid_reg && stat_offset_reg == 8'h04;
  always_ff @(posedge ref_clk) if (take) id_reg <= cmd_ident;

  pass_start_a: assert property (
    take && destination_selector <= 8'h07 |=> exec_start_reg)
    else $error("target command not started");
  board_code_a: assert property (
    take && destination_selector == 8'hff |=> !exec_start_reg ||
    (board_ctrl_reg && board_cmd_reg == $past(cmd_code)))
    else $error("board code not captured");
  bad_sel_a: assert property (
    take && destination_selector inside {[8'h08:8'hfe]}
    |=> !exec_start_reg ##[1:4] stat_valid_reg)
    else $error("bad selector not refused");
  status_lat_a: assert property (
    exec_done && clk_en && !cmd_ready && !stat_valid_reg |-> ##2
    stat_valid_reg && stat_offset_reg == 8'h00 && stat_block_reg == 2'h0)
    else $error("status late or misplaced");
  ident_a: assert property (
    stat_valid_reg && stat_offset_reg == 8'h00 |-> stat_word_reg == id_reg)
    else $error("identifier not copied");
  done_flag_a: assert property (flg |-> stat_word_reg[24])
    else $error("done bit clear in status");
  cont_bit_a: assert property (
    flg |-> stat_word_reg[28] == (stat_block_reg != 2'h0))
    else $error("continued bit wrong");
  board_flags_a: assert property (
    flg && board_ctrl_reg |-> stat_word_reg[31:26] == 6'h00)
    else $error("reserved board flag set");
  hold_a: assert property (
    stat_valid_reg && !stat_ready |=> stat_valid_reg &&
    $stable(stat_word_reg) && $stable(stat_offset_reg))
    else $error("status word dropped");
  last_word_a: assert property (
    stat_valid_reg && stat_ready && stat_last_reg |->
    stat_offset_reg == 8'h0c ##[1:2] command_done_bit_reg)
    else $error("last word misplaced");
endmodule
`default_nettype wire

// [dv/hsb_host_model.sv]
// Host stand-in: status word sink and sense byte store.
// Assumes the reporter's ready handshake and same-cycle sense reads.
`timescale 1ns/100ps
`default_nettype none
module hsb_host_model (
  // Clock, reset, pacing
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic slow,
  input wire logic clr,
  // Status words
  input wire logic stat_valid_reg,
  output logic stat_ready,
  input wire logic [31:0] stat_word_reg,
  input wire logic [7:0] stat_offset_reg,
  input wire logic [1:0] stat_block_reg,
  // Sense buffer
  input wire logic [31:0] sense_rd_idx,
  output logic [31:0] sense_rd_data
);
  logic [31:0] mem [0:15];
  logic [7:0] n_words_reg;
  logic ph_reg;
  // Slow host takes a word only every other cycle
  assign stat_ready = !slow || ph_reg;
  // Sense byte n holds n xor a5, so order slips show
  assign sense_rd_data = sense_rd_idx ^ 32'ha5a5a5a5;
  always_ff @(posedge ref_clk) begin
    ph_reg <= !sys_rst && !ph_reg;
    n_words_reg <= (sys_rst || clr) ? 8'h00 : n_words_reg +
      8'(stat_valid_reg && stat_ready);
    if (stat_valid_reg && stat_ready)
      mem[{stat_block_reg, stat_offset_reg[3:2]}] <= stat_word_reg;
  end
endmodule
`default_nettype wire

// [dv/hsb_reporter_test.sv]
// Self-checking bench of the status block reporter.
// Assumes hsb_reporter, the host model and the property checker.
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin n_fail++; \
  $display("unexpected at %0t: %h vs %h", $time, a, b); end end
module hsb_reporter_test;
  logic ref_clk, sys_rst, clk_en, cmd_valid, exec_done, exec_error, slow, clr;
  logic data_truncated, retried, check_condition, sense_inhibit, ext_unit_opts;
  logic cmd_ready, pass_through_reg, board_ctrl_reg, exec_start_reg;
  logic stat_valid_reg, stat_ready, stat_last_reg, command_done_bit_reg;
  logic [31:0] cmd_ident, sense_rd_idx, sense_rd_data, stat_word_reg;
  logic [7:0] destination_selector, cmd_code, board_cmd_reg, exec_err_code;
  logic [7:0] scsi_status, stat_offset_reg;
  logic [5:0] sense_count;
  logic [2:0] target_reg;
  logic [1:0] stat_block_reg;
  logic [127:0] sel_fields;
  logic [7:0] codes [11] = '{8'h01, 8'h02, 8'h05, 8'h06, 8'h07, 8'h08,
    8'h09, 8'h10, 8'h15, 8'h16, 8'h18};
  int n_fail, n_checks;

  hsb_reporter hsb_reporter_i (.ref_clk, .sys_rst, .clk_en, .cmd_valid,
    .cmd_ready, .cmd_ident, .destination_selector, .cmd_code,
    .pass_through_reg, .board_ctrl_reg, .target_reg, .board_cmd_reg,
    .exec_start_reg, .exec_done, .exec_error, .exec_err_code, .scsi_status,
    .data_truncated, .retried, .check_condition, .sense_inhibit,
    .sense_count, .ext_unit_opts, .sel_fields, .sense_rd_idx, .sense_rd_data,
    .stat_valid_reg, .stat_ready, .stat_word_reg, .stat_offset_reg,
    .stat_block_reg, .stat_last_reg, .command_done_bit_reg);
  hsb_host_model host_i (.ref_clk, .sys_rst, .slow, .clr, .stat_valid_reg,
    .stat_ready, .stat_word_reg, .stat_offset_reg, .stat_block_reg,
    .sense_rd_idx, .sense_rd_data);

  // Free-running 10 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = !ref_clk;
  end

  task automatic stop_test;
    $display("checks %0d, failures %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // One command through intake, execution and status collection
  task automatic run(input logic [7:0] dst, input logic [7:0] cd);
    logic [255:0] eb;
    logic [31:0] id;
    logic [7:0] fl, ec;
    logic pass, ok, er, sel;
    int n, nb, t;
    id = {cd, dst, 16'h5a3c};
    @(posedge ref_clk);
    cmd_valid <= 1'b1;
    clr <= 1'b1;
    cmd_ident <= id;
    destination_selector <= dst;
    cmd_code <= cd;
    @(posedge ref_clk);
    cmd_valid <= 1'b0;
    clr <= 1'b0;
    pass = dst <= 8'h07;
    ok = pass || dst == 8'hff && cd inside {codes};
    #1;
    `CHK(exec_start_reg, ok)
    if (ok) begin
      `CHK(pass_through_reg, pass)
      if (pass) `CHK(target_reg, dst[2:0])
      else `CHK(board_cmd_reg, cd)
      @(posedge ref_clk);
      exec_done <= 1'b1;
      @(posedge ref_clk);
      exec_done <= 1'b0;
    end
    // Slow host may still hold the last word after the done bit
    for (t = 0; t < 300 && !(command_done_bit_reg === 1'b1 &&
        stat_valid_reg === 1'b0); t++) begin
      @(posedge ref_clk);
      #1;
    end
    if (t == 300) begin
      n_fail++;
      stop_test;
    end
    er = !ok || exec_error;
    ec = !ok ? (dst == 8'hff ? 8'h41 : 8'h40) : exec_error ? exec_err_code : 8'h00;
    eb = '0;
    n = 0;
    sel = sense_count == 6'h00 && sel_fields != '0;
    if (pass && check_condition && !sense_inhibit) begin
      n = sense_count > 6'h20 ? 32 : int'(sense_count);
      if (n == 0) n = sel && ext_unit_opts ? 16 : 8;
      for (int i = 0; i < n; i++)
        eb[8*i +: 8] = (sel ? sel_fields[8*i +: 8] : 8'(i)) ^ 8'ha5;
    end
    nb = n == 0 ? 1 : (n + 7) / 8;
    `CHK(host_i.n_words_reg, 8'(4 * nb))
    for (int b = 0; b < nb; b++) begin
      fl = {3'b000, pass && b > 0, pass && data_truncated, pass && retried,
        er, 1'b1};
      `CHK(host_i.mem[4*b], id)
      `CHK(host_i.mem[4*b+1], {fl, ec, pass ? scsi_status : 8'h00, 8'h00})
      `CHK(host_i.mem[4*b+2], eb[64*b +: 32])
      `CHK(host_i.mem[4*b+3], eb[64*b+32 +: 32])
    end
  endtask

  // Main sequence
  initial begin
    {sys_rst, clk_en} = 2'b11;
    {cmd_valid, exec_done, exec_error, slow, clr, data_truncated} = '0;
    {retried, check_condition, sense_inhibit, ext_unit_opts} = '0;
    {cmd_ident, destination_selector, cmd_code, exec_err_code} = '0;
    {scsi_status, sense_count, sel_fields} = '0;
    repeat (6) @(posedge ref_clk);
    sys_rst <= 1'b0;
    foreach (codes[i]) begin
      exec_error <= (i % 2) == 1;
      exec_err_code <= (i % 2) == 1 ? 8'h11 : 8'h00;
      run(8'hff, codes[i]);
    end
    exec_error <= 1'b0;
    run(8'h08, 8'h01);
    run(8'hff, 8'h03);
    {exec_error, retried, data_truncated, check_condition, slow} <= 5'h1f;
    exec_err_code <= 8'h24;
    scsi_status <= 8'h02;
    sense_count <= 6'd20;
    sel_fields <= {16{8'h3c}};
    run(8'h05, 8'h00);
    exec_error <= 1'b0;
    sense_count <= 6'd40;
    run(8'h07, 8'h00);
    sense_count <= 6'd0;
    ext_unit_opts <= 1'b1;
    sel_fields <= 128'h17_7a_0c_21_0d_39_13_38_07_03_04_05_06_02_01_00;
    run(8'h00, 8'h00);
    ext_unit_opts <= 1'b0;
    run(8'h01, 8'h00);
    sel_fields <= '0;
    run(8'h02, 8'h00);
    sense_inhibit <= 1'b1;
    run(8'h03, 8'h00);
    {sense_inhibit, check_condition} <= 2'b00;
    run(8'h04, 8'h00);
    // Enable low freezes intake: an offered block stays untaken
    @(posedge ref_clk);
    clk_en <= 1'b0;
    cmd_valid <= 1'b1;
    repeat (3) @(posedge ref_clk);
    #1;
    `CHK(command_done_bit_reg, 1'b1)
    `CHK(exec_start_reg, 1'b0)
    @(posedge ref_clk);
    {clk_en, cmd_valid} <= 2'b10;
    @(posedge ref_clk);
    stop_test;
  end
endmodule
bind hsb_reporter hsb_reporter_properties hsb_reporter_properties_i (
  .ref_clk, .sys_rst, .clk_en, .cmd_valid, .cmd_ready, .cmd_ident,
  .destination_selector, .cmd_code, .board_ctrl_reg, .board_cmd_reg,
  .exec_start_reg, .exec_done, .stat_valid_reg, .stat_ready, .stat_word_reg,
  .stat_offset_reg, .stat_block_reg, .stat_last_reg, .command_done_bit_reg);
`default_nettype wire
